// ===== stc_defs.svh
// offsets, field positions, reset values and widths of the
// counter threshold flag block; definitions only
// assumes it is included by its bare name before use
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define STC_AW          12
`define STC_OFF_CTRL    12'h100
`define STC_OFF_RXFLAG  12'h104
`define STC_OFF_TXFLAG  12'h108
`define STC_OFF_RXMASK  12'h10C
`define STC_OFF_TXMASK  12'h110
`define STC_OFF_ISTAT   12'h120
`define STC_OFF_IMASK   12'h124

// ----------------------------------------
// fields, sizes and reset values
// ----------------------------------------
`define STC_RX_N        24
`define STC_TX_N        25
`define STC_CTRL_NOWRAP 1
`define STC_IRQ_RX      0
`define STC_IRQ_TX      1
`define STC_IRQ_N       2
`define STC_HALF32      32'h8000_0000
`define STC_MAX32       32'hFFFF_FFFF
`define STC_HALF16      16'h8000
`define STC_MAX16       16'hFFFF
`define STC_WORD_ZERO   32'h0000_0000

`endif

// ===== stc_pkg.sv
// shared types of the counter threshold flag block
// assumes stc_defs.svh supplies the sizes
`include "stc_defs.svh"

package stc_pkg;
  // one-hot direction code of a summary event
  typedef enum logic [1:0]
  {
    stc_dir_rx = 2'b01,
    stc_dir_tx = 2'b10
  } stc_dir_t;

  typedef logic [31:0] stc_word_t;
endpackage

// ===== stc_flag_bank.sv
// one bank of sticky threshold flags, one per statistics counter
// assumes each counter reports its new value with an update
// pulse, and a read pulse when software reads that counter
`timescale 1ns/1ns
`include "stc_defs.svh"

module stc_flag_bank
#(
  parameter int          N    = `STC_RX_N,
  parameter logic [N-1:0] WIDE = '1
)
(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // counter side
  input  wire logic [N-1:0]        upd,
  input  wire logic [N-1:0][31:0]  val,
  input  wire logic [N-1:0]        rd,
  input  wire logic                rd_lane0,
  // flag side
  output      logic [N-1:0]        set_evt,
  output      logic [N-1:0]        flags_q
);
  import stc_pkg::*;

  logic [N-1:0] clr;

  // ----------------------------------------
  // per-counter threshold detection
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      logic hit32;
      logic hit16;
      // a held counter keeps reporting all ones, so max re-fires
      assign hit32 = (val[i] == `STC_HALF32) || (val[i] == `STC_MAX32);
      assign hit16 = (val[i][15:0] == `STC_HALF16) ||
                     (val[i][15:0] == `STC_MAX16);
      assign set_evt[i] = upd[i] && (WIDE[i] ? hit32 : hit16);
      // only a read covering byte lane 0 clears
      assign clr[i] = rd[i] && rd_lane0;
    end
  endgenerate

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flags_q <= '0;
    else
      flags_q <= (flags_q & ~clr) | set_evt;
  end
endmodule

// ===== stc_irq_sum.sv
// summary interrupt status with write-one-to-clear and a mask
// assumes event pulses are one cycle wide in the clock domain
`timescale 1ns/1ns
`include "stc_defs.svh"

module stc_irq_sum
#(
  parameter int N = `STC_IRQ_N
)
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // events
  input  wire logic [N-1:0]  evt,
  // software access
  input  wire logic          wr_status,
  input  wire logic          wr_mask,
  input  wire logic [N-1:0]  wdata,
  // state and interrupt
  output      logic [N-1:0]  status_q,
  output      logic [N-1:0]  mask_q,
  output      logic          irq
);
  import stc_pkg::*;

  logic [N-1:0] w1c;

  assign w1c = wr_status ? wdata : '0;

  // sticky status, event wins over a write-one clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_q <= '0;
    else
      status_q <= (status_q & ~w1c) | evt;
  end

  // mask: a one keeps that status bit off irq
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= wdata;
  end

  assign irq = |(status_q & ~mask_q);
endmodule

// ===== stc_top.sv
// statistics counter threshold flags: receive and transmit
// flag registers, their masks, the no-wrap control and interrupts
// assumes the counters sit outside, report each new value with a
// one-cycle update pulse and each software read with a read pulse
// and the byte lanes that read covered
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "stc_defs.svh"

module stc_top
#(
  parameter int                RX_N    = `STC_RX_N,
  parameter int                TX_N    = `STC_TX_N,
  parameter logic [RX_N-1:0]   RX_WIDE = '1,
  parameter logic [TX_N-1:0]   TX_WIDE = '1
)
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // register port
  input  wire logic [`STC_AW-1:0]        reg_addr,
  input  wire stc_pkg::stc_word_t        reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output      stc_pkg::stc_word_t        reg_rdata,
  // receive counters
  input  wire logic [RX_N-1:0]           rx_cnt_upd,
  input  wire logic [RX_N-1:0][31:0]     rx_cnt_val,
  input  wire logic [RX_N-1:0]           rx_cnt_rd,
  // transmit counters
  input  wire logic [TX_N-1:0]           tx_cnt_upd,
  input  wire logic [TX_N-1:0][31:0]     tx_cnt_val,
  input  wire logic [TX_N-1:0]           tx_cnt_rd,
  // lanes of the counter read in progress
  input  wire logic [3:0]                cnt_rd_lanes,
  // counter control
  output      logic                      cnt_no_wrap,
  // interrupts
  output      logic                      rx_irq,
  output      logic                      tx_irq,
  output      logic                      irq
);
  import stc_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [RX_N-1:0]        rx_flags_q;
  logic [TX_N-1:0]        tx_flags_q;
  logic [RX_N-1:0]        rx_mask_q;
  logic [TX_N-1:0]        tx_mask_q;
  logic [RX_N-1:0]        rx_set;
  logic [TX_N-1:0]        tx_set;
  logic                   no_wrap_q;
  logic                   rd_lane0;
  logic [`STC_IRQ_N-1:0]  sum_evt;
  logic [`STC_IRQ_N-1:0]  istat_q;
  logic [`STC_IRQ_N-1:0]  imask_q;
  logic                   wr_ctrl;
  logic                   wr_rxmask;
  logic                   wr_txmask;
  logic                   wr_istat;
  logic                   wr_imask;
  stc_word_t              rdata_d;
  stc_word_t              rdata_q;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // flag registers have no write strobe at all, so writes vanish
  always_comb
  begin
    wr_ctrl   = 1'b0;
    wr_rxmask = 1'b0;
    wr_txmask = 1'b0;
    wr_istat  = 1'b0;
    wr_imask  = 1'b0;
    if (!reg_wr)
      wr_ctrl = 1'b0;
    else if (reg_addr == `STC_OFF_CTRL)
      wr_ctrl = 1'b1;
    else if (reg_addr == `STC_OFF_RXMASK)
      wr_rxmask = 1'b1;
    else if (reg_addr == `STC_OFF_TXMASK)
      wr_txmask = 1'b1;
    else if (reg_addr == `STC_OFF_ISTAT)
      wr_istat = 1'b1;
    else if (reg_addr == `STC_OFF_IMASK)
      wr_imask = 1'b1;
  end

  // ----------------------------------------
  // control and mask registers
  // ----------------------------------------
  // no-wrap option, steers the outside counters
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      no_wrap_q <= 1'b0;
    else if (wr_ctrl)
      no_wrap_q <= reg_wdata[`STC_CTRL_NOWRAP];
  end

  assign cnt_no_wrap = no_wrap_q;

  // receive mask, same layout as the receive flags
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rx_mask_q <= '0;
    else if (wr_rxmask)
      rx_mask_q <= reg_wdata[RX_N-1:0];
  end

  // transmit mask, same layout as the transmit flags
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      tx_mask_q <= '0;
    else if (wr_txmask)
      tx_mask_q <= reg_wdata[TX_N-1:0];
  end

  // ----------------------------------------
  // flag banks
  // ----------------------------------------
  // byte lane 0 must be part of the counter read to clear
  assign rd_lane0 = cnt_rd_lanes[0];

  // input bit k belongs to the counter of flag bit k, so the
  // receive order runs watchdog (23) down to all frames (0)
  // and max detection ignores no-wrap: a held counter still hits
  stc_flag_bank
  #(
    .N    (RX_N),
    .WIDE (RX_WIDE)
  )
  u_rx_bank
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .upd      (rx_cnt_upd),
    .val      (rx_cnt_val),
    .rd       (rx_cnt_rd),
    .rd_lane0 (rd_lane0),
    .set_evt  (rx_set),
    .flags_q  (rx_flags_q)
  );

  // transmit order runs vlan (24) down to all bytes (0)
  stc_flag_bank
  #(
    .N    (TX_N),
    .WIDE (TX_WIDE)
  )
  u_tx_bank
  (
    .clock    (clock),
    .rst_n    (rst_n),
    .upd      (tx_cnt_upd),
    .val      (tx_cnt_val),
    .rd       (tx_cnt_rd),
    .rd_lane0 (rd_lane0),
    .set_evt  (tx_set),
    .flags_q  (tx_flags_q)
  );

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // per-direction summaries of unmasked flags
  assign rx_irq = |(rx_flags_q & ~rx_mask_q);
  assign tx_irq = |(tx_flags_q & ~tx_mask_q);

  // a masked flag still latches, it only feeds no event
  assign sum_evt[`STC_IRQ_RX] = |(rx_set & ~rx_mask_q);
  assign sum_evt[`STC_IRQ_TX] = |(tx_set & ~tx_mask_q);

  stc_irq_sum
  #(
    .N (`STC_IRQ_N)
  )
  u_irq
  (
    .clock     (clock),
    .rst_n     (rst_n),
    .evt       (sum_evt),
    .wr_status (wr_istat),
    .wr_mask   (wr_imask),
    .wdata     (reg_wdata[`STC_IRQ_N-1:0]),
    .status_q  (istat_q),
    .mask_q    (imask_q),
    .irq       (irq)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // unmapped offsets and upper bits read zero
  always_comb
  begin
    rdata_d = `STC_WORD_ZERO;
    if (!reg_rd)
      rdata_d = `STC_WORD_ZERO;
    else if (reg_addr == `STC_OFF_CTRL)
      rdata_d[`STC_CTRL_NOWRAP] = no_wrap_q;
    else if (reg_addr == `STC_OFF_RXFLAG)
      rdata_d[RX_N-1:0] = rx_flags_q;
    else if (reg_addr == `STC_OFF_TXFLAG)
      rdata_d[TX_N-1:0] = tx_flags_q;
    else if (reg_addr == `STC_OFF_RXMASK)
      rdata_d[RX_N-1:0] = rx_mask_q;
    else if (reg_addr == `STC_OFF_TXMASK)
      rdata_d[TX_N-1:0] = tx_mask_q;
    else if (reg_addr == `STC_OFF_ISTAT)
      rdata_d[`STC_IRQ_N-1:0] = istat_q;
    else if (reg_addr == `STC_OFF_IMASK)
      rdata_d[`STC_IRQ_N-1:0] = imask_q;
  end

  // data stand one cycle after the strobe and only then
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_q <= `STC_WORD_ZERO;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_rx_half;
    @(posedge clock) disable iff (!rst_n)
    rx_cnt_upd[RX_N-1] && RX_WIDE[RX_N-1] &&
    rx_cnt_val[RX_N-1] == `STC_HALF32
    |=> rx_flags_q[RX_N-1];
  endproperty
  a_rx_half: assert property (p_rx_half)
    else $error("rx half value did not set flag");

  property p_tx_max;
    @(posedge clock) disable iff (!rst_n)
    tx_cnt_upd[TX_N-1] && TX_WIDE[TX_N-1] &&
    tx_cnt_val[TX_N-1] == `STC_MAX32
    |=> tx_flags_q[TX_N-1] ##1 tx_flags_q[TX_N-1] || tx_cnt_rd[TX_N-1];
  endproperty
  a_tx_max: assert property (p_tx_max)
    else $error("tx max value did not set flag");

  property p_nowrap_max;
    @(posedge clock) disable iff (!rst_n)
    no_wrap_q && tx_cnt_upd[0] && TX_WIDE[0] &&
    tx_cnt_val[0] == `STC_MAX32
    |=> tx_flags_q[0];
  endproperty
  a_nowrap_max: assert property (p_nowrap_max)
    else $error("held maximum did not set flag");

  property p_rd_clear;
    @(posedge clock) disable iff (!rst_n)
    rx_cnt_rd[0] && cnt_rd_lanes[0] && !rx_cnt_upd[0]
    |=> !rx_flags_q[0];
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("counter read did not clear flag");

  // no flag of either bank may fall unless lane 0 was part of the read
  property p_lane_only;
    @(posedge clock) disable iff (!rst_n)
    !cnt_rd_lanes[0]
    |=> (~rx_flags_q & $past(rx_flags_q)) == '0 &&
        (~tx_flags_q & $past(tx_flags_q)) == '0;
  endproperty
  a_lane_only: assert property (p_lane_only)
    else $error("flag cleared without lane 0 read");

  property p_flag_read_keeps;
    @(posedge clock) disable iff (!rst_n)
    reg_rd && reg_addr == `STC_OFF_RXFLAG && rx_flags_q[5] &&
    !rx_cnt_rd[5] |=> rx_flags_q[5] && reg_rdata[5];
  endproperty
  a_flag_read_keeps: assert property (p_flag_read_keeps)
    else $error("flag register read lost a flag");

  property p_upper_zero;
    @(posedge clock) disable iff (!rst_n)
    reg_rd && (reg_addr == `STC_OFF_RXFLAG ||
    reg_addr == `STC_OFF_TXFLAG)
    |=> reg_rdata[31:RX_N+1] == '0 &&
    ($past(reg_addr) == `STC_OFF_TXFLAG || !reg_rdata[RX_N]);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved flag bits not zero");

  property p_no_sw_write;
    @(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == `STC_OFF_RXFLAG &&
    rx_cnt_upd == '0 && rx_cnt_rd == '0
    |=> $stable(rx_flags_q);
  endproperty
  a_no_sw_write: assert property (p_no_sw_write)
    else $error("software write changed flags");

  property p_nowrap_ctrl;
    @(posedge clock) disable iff (!rst_n)
    wr_ctrl |=> cnt_no_wrap == $past(reg_wdata[`STC_CTRL_NOWRAP]);
  endproperty
  a_nowrap_ctrl: assert property (p_nowrap_ctrl)
    else $error("no-wrap control not taken");

  // a masked set latches but reaches neither rx_irq nor the summary
  property p_mask_blocks;
    @(posedge clock) disable iff (!rst_n)
    (rx_set & ~rx_mask_q) == '0 && (rx_flags_q & ~rx_mask_q) == '0 &&
    !istat_q[`STC_IRQ_RX] && !wr_rxmask
    |=> !rx_irq && !istat_q[`STC_IRQ_RX];
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked flag raised rx interrupt");

  property p_summary;
    @(posedge clock) disable iff (!rst_n)
    tx_set[1] && !tx_mask_q[1] && !wr_txmask |=> tx_irq && irq ||
    imask_q[`STC_IRQ_TX];
  endproperty
  a_summary: assert property (p_summary)
    else $error("unmasked tx flag gave no interrupt");

  c_half_set: cover property (@(posedge clock) disable iff (!rst_n)
    rx_set[0] ##1 rx_flags_q[0]);
  c_read_clear: cover property (@(posedge clock) disable iff (!rst_n)
    rx_flags_q[0] && rx_cnt_rd[0] && cnt_rd_lanes[0] ##1 !rx_flags_q[0]);
  c_nowrap: cover property (@(posedge clock) disable iff (!rst_n)
    no_wrap_q && tx_set[0]);
  c_irq: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(irq));
endmodule

// ===== stc_tb.sv
// self-checking bench of the counter threshold flag block
// assumes stc_top with its defaults, counter 0 of rx made 16-bit
`timescale 1ns/1ns
`include "stc_defs.svh"

module testbench;
  import stc_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                  clock;
  logic                  rst_n;
  logic [11:0]           reg_addr;
  stc_word_t             reg_wdata;
  stc_word_t             reg_rdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [23:0]           rx_cnt_upd;
  logic [23:0][31:0]     rx_cnt_val;
  logic [23:0]           rx_cnt_rd;
  logic [24:0]           tx_cnt_upd;
  logic [24:0][31:0]     tx_cnt_val;
  logic [24:0]           tx_cnt_rd;
  logic [3:0]            cnt_rd_lanes;
  logic                  cnt_no_wrap;
  logic                  rx_irq;
  logic                  tx_irq;
  logic                  irq;
  int                    fail_count;
  int                    checks_done;
  logic [11:0]           offs [8];

  // bit 0 of rx is a 16-bit counter so both half values get exercised
  stc_top #(.RX_WIDE(24'hFF_FFFE)) dut_u
  (
    .clock        (clock),
    .rst_n        (rst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .rx_cnt_upd   (rx_cnt_upd),
    .rx_cnt_val   (rx_cnt_val),
    .rx_cnt_rd    (rx_cnt_rd),
    .tx_cnt_upd   (tx_cnt_upd),
    .tx_cnt_val   (tx_cnt_val),
    .tx_cnt_rd    (tx_cnt_rd),
    .cnt_rd_lanes (cnt_rd_lanes),
    .cnt_no_wrap  (cnt_no_wrap),
    .rx_irq       (rx_irq),
    .tx_irq       (tx_irq),
    .irq          (irq)
  );

  // 20 MHz clock
  always #25 clock = ~clock;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one-cycle write strobe, dropped at the edge that takes it
  task automatic reg_write(input logic [11:0] a, input stc_word_t d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    @(negedge clock);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_check(input logic [11:0] a, input stc_word_t exp,
                           input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    check(what, reg_rdata, exp);
  endtask

  // one counter reports a new value for one cycle
  task automatic cnt_update(input bit tx, input int k,
                            input logic [31:0] v);
    @(posedge clock);
    if (tx)
    begin
      tx_cnt_upd[k] <= 1'b1;
      tx_cnt_val[k] <= v;
    end
    else
    begin
      rx_cnt_upd[k] <= 1'b1;
      rx_cnt_val[k] <= v;
    end
    @(posedge clock);
    rx_cnt_upd <= '0;
    tx_cnt_upd <= '0;
    @(negedge clock);
  endtask

  // software read of one counter covering the given byte lanes
  task automatic cnt_read(input bit tx, input int k,
                          input logic [3:0] lanes);
    @(posedge clock);
    if (tx)
      tx_cnt_rd[k] <= 1'b1;
    else
      rx_cnt_rd[k] <= 1'b1;
    cnt_rd_lanes <= lanes;
    @(posedge clock);
    rx_cnt_rd <= '0;
    tx_cnt_rd <= '0;
    @(negedge clock);
  endtask

  // report a value, expect the flag or not, then clear it again
  task automatic thr(input bit tx, input int k, input logic [31:0] v,
                     input bit e);
    cnt_update(tx, k, v);
    reg_check(tx ? `STC_OFF_TXFLAG : `STC_OFF_RXFLAG,
              e ? (32'h1 << k) : 32'h0, "threshold flag");
    cnt_read(tx, k, 4'h1);
  endtask

  // ----------------------------------------
  // watchdog: the sequence needs some five hundred cycles, the limit is 20000
  // ----------------------------------------
  initial
  begin
    #(20000 * 50);
    fail_count++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    clock        = 1'b0;
    rst_n        = 1'b0;
    reg_addr     = '0;
    reg_wdata    = '0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    rx_cnt_upd   = '0;
    rx_cnt_val   = '0;
    rx_cnt_rd    = '0;
    tx_cnt_upd   = '0;
    tx_cnt_val   = '0;
    tx_cnt_rd    = '0;
    cnt_rd_lanes = '0;
    fail_count   = 0;
    checks_done  = 0;
    offs         = '{`STC_OFF_CTRL, `STC_OFF_RXFLAG, `STC_OFF_TXFLAG,
                     `STC_OFF_RXMASK, `STC_OFF_TXMASK, `STC_OFF_ISTAT,
                     `STC_OFF_IMASK, 12'h200};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // every register starts at zero, unmapped space too
    foreach (offs[i])
      reg_check(offs[i], 32'h0, "reset");
    @(negedge clock);
    check("rdata idle", reg_rdata, 32'h0);
    check("irq idle", {29'h0, rx_irq, tx_irq, irq}, 32'h0);
    // flag registers ignore writes; the upper bits stay zero
    reg_write(`STC_OFF_RXFLAG, 32'hFFFF_FFFF);
    reg_write(`STC_OFF_TXFLAG, 32'hFFFF_FFFF);
    reg_write(12'h200, 32'hFFFF_FFFF);
    reg_check(`STC_OFF_RXFLAG, 32'h0, "rx flags written");
    reg_check(`STC_OFF_TXFLAG, 32'h0, "tx flags written");
    reg_check(12'h200, 32'h0, "unmapped");
    // each counter raises exactly its own bit, and its read clears it
    for (int k = 0; k < 24; k++)
    begin
      cnt_update(0, k, (k == 0) ? 32'h0000_8000 : 32'h8000_0000);
      reg_check(`STC_OFF_RXFLAG, 32'h1 << k, "rx bit");
      check("rx_irq set", {31'h0, rx_irq}, 32'h1);
      cnt_read(0, k, 4'h1);
      reg_check(`STC_OFF_RXFLAG, 32'h0, "rx clear");
    end
    for (int k = 0; k < 25; k++)
    begin
      cnt_update(1, k, 32'hFFFF_FFFF);
      reg_check(`STC_OFF_TXFLAG, 32'h1 << k, "tx bit");
      check("tx_irq set", {31'h0, tx_irq}, 32'h1);
      cnt_read(1, k, 4'h1);
      check("tx_irq clear", {31'h0, tx_irq}, 32'h0);
    end
    reg_write(`STC_OFF_ISTAT, 32'h0000_0003);
    // only the exact half and full values count
    thr(0, 5, 32'h7FFF_FFFF, 0);
    thr(0, 5, 32'h8000_0001, 0);
    thr(0, 5, 32'h8000_0000, 1);
    thr(0, 5, 32'hFFFF_FFFE, 0);
    thr(0, 5, 32'hFFFF_FFFF, 1);
    thr(0, 0, 32'h0000_7FFF, 0);
    thr(0, 0, 32'h8000_0000, 0);
    thr(0, 0, 32'h0000_FFFF, 1);
    // no-wrap: control bit 1 alone, a held maximum sets again
    reg_write(`STC_OFF_CTRL, 32'hFFFF_FFFF);
    reg_check(`STC_OFF_CTRL, 32'h0000_0002, "ctrl");
    check("no wrap", {31'h0, cnt_no_wrap}, 32'h1);
    thr(1, 0, 32'hFFFF_FFFF, 1);
    thr(1, 0, 32'hFFFF_FFFF, 1);
    reg_write(`STC_OFF_CTRL, 32'h0);
    check("wrap", {31'h0, cnt_no_wrap}, 32'h0);
    // reading flags, writing flags or a read missing lane 0 keeps it
    cnt_update(0, 9, 32'hFFFF_FFFF);
    reg_check(`STC_OFF_RXFLAG, 32'h0000_0200, "kept 1");
    reg_write(`STC_OFF_RXFLAG, 32'h0);
    reg_check(`STC_OFF_RXFLAG, 32'h0000_0200, "kept 2");
    cnt_read(0, 9, 4'hE);
    reg_check(`STC_OFF_RXFLAG, 32'h0000_0200, "kept 3");
    cnt_read(0, 9, 4'hF);
    reg_check(`STC_OFF_RXFLAG, 32'h0, "lane 0 read");
    reg_write(`STC_OFF_ISTAT, 32'h0000_0003);
    // summary status is sticky until written with a one
    cnt_update(0, 12, 32'h8000_0000);
    check("irq up", {30'h0, rx_irq, irq}, 32'h3);
    reg_check(`STC_OFF_ISTAT, 32'h0000_0001, "istat rx");
    cnt_read(0, 12, 4'h1);
    check("irq sticky", {30'h0, rx_irq, irq}, 32'h1);
    reg_write(`STC_OFF_ISTAT, 32'h0000_0001);
    @(negedge clock);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // a masked flag still latches but raises no interrupt
    reg_write(`STC_OFF_RXMASK, 32'hFFFF_FFFF);
    reg_check(`STC_OFF_RXMASK, 32'h00FF_FFFF, "rx mask");
    cnt_update(0, 12, 32'h8000_0000);
    check("masked", {30'h0, rx_irq, irq}, 32'h0);
    reg_check(`STC_OFF_RXFLAG, 32'h0000_1000, "masked flag");
    cnt_read(0, 12, 4'h1);
    reg_write(`STC_OFF_RXMASK, 32'h0);
    reg_write(`STC_OFF_TXMASK, 32'hFFFF_FFFF);
    reg_check(`STC_OFF_TXMASK, 32'h01FF_FFFF, "tx mask");
    reg_write(`STC_OFF_TXMASK, 32'h0);
    // summary mask blocks the line but not the status bit
    reg_write(`STC_OFF_IMASK, 32'h0000_0002);
    cnt_update(1, 20, 32'h8000_0000);
    check("tx summary", {30'h0, tx_irq, irq}, 32'h2);
    reg_check(`STC_OFF_ISTAT, 32'h0000_0002, "istat tx");
    reg_write(`STC_OFF_ISTAT, 32'h0000_0002);
    cnt_read(1, 20, 4'h1);
    reg_write(`STC_OFF_IMASK, 32'h0);
    reg_check(`STC_OFF_ISTAT, 32'h0, "istat end");
    // a reset in mid-run drops flags, masks, control and summary
    reg_write(`STC_OFF_RXMASK, 32'h0000_0001);
    reg_write(`STC_OFF_CTRL, 32'h0000_0002);
    cnt_update(0, 7, 32'h8000_0000);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    reg_check(`STC_OFF_RXFLAG, 32'h0, "flags after reset");
    reg_check(`STC_OFF_RXMASK, 32'h0, "mask after reset");
    reg_check(`STC_OFF_ISTAT, 32'h0, "istat after reset");
    check("outs after reset", {28'h0, cnt_no_wrap, rx_irq, tx_irq, irq},
          32'h0);
    results();
  end
endmodule
